// ===== design/headset_detect_pkg.sv
package headset_detect_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets, as seen on the command-byte side of the host bus.

	localparam logic [7:0] DETECT_CONTROL_ADDR  = 8'h41;
	localparam logic [7:0] DETECT_RESULT_ADDR   = 8'h05;
	localparam logic [7:0] STATUS_FLAGS_ADDR    = 8'h06;
	localparam logic [7:0] STATUS_IRQ_MASK_ADDR = 8'h07;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.

	localparam logic [7:0] DETECT_CONTROL_RESET  = 8'h00;
	localparam logic [7:0] DETECT_RESULT_RESET   = 8'h00;
	localparam logic [7:0] STATUS_FLAGS_RESET    = 8'h00;
	localparam logic [7:0] STATUS_IRQ_MASK_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE   = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions of the detection control register.

	localparam int CTRL_FORCE_INDICATOR_LOW_BIT  = 4;
	localparam int CTRL_PIN_TRIGGER_DISABLE_BIT  = 3;
	localparam int CTRL_INDICATOR_IRQ_MODE_BIT   = 2;
	localparam int CTRL_AUTO_ROUTE_DISABLE_BIT   = 1;
	localparam int CTRL_DETECT_START_BIT         = 0;
	localparam logic [7:0] CTRL_STORED_MASK      = 8'h1E;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions of the result register.

	localparam int RESULT_GROUND_BAND_BIT        = 6;
	localparam int RESULT_TIP_SLEEVE_MSB         = 5;
	localparam int RESULT_TIP_SLEEVE_LSB         = 3;
	localparam int RESULT_TIP_RING2_MSB          = 2;
	localparam int RESULT_TIP_RING2_LSB          = 0;
	localparam logic [7:0] RESULT_WRITABLE_MASK  = 8'h7F;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions of the status flag and mask registers.

	localparam int FLAG_DETECT_FAILURE_BIT       = 3;
	localparam int FLAG_MIC_FOUND_BIT            = 1;
	localparam int FLAG_THREE_POLE_FOUND_BIT     = 0;
	localparam int MASK_INDICATOR_TRISTATE_BIT   = 4;
	localparam logic [7:0] FLAG_EVENT_MASK       = 8'h0B;
	localparam logic [7:0] IRQ_MASK_STORED_MASK  = 8'h1B;

	////////////////////////////////////////////////////////////////////////////////
	// Timing.

	localparam int TRIGGER_DELAY_MS   = 120;
	localparam int CORE_CLK_KHZ       = 125000;
	localparam int TRIGGER_DELAY_CYC  = TRIGGER_DELAY_MS * CORE_CLK_KHZ;
	localparam int DELAY_COUNT_WIDTH  = 24;

	////////////////////////////////////////////////////////////////////////////////
	// Detection sequencer states.

	typedef enum logic [2:0] {
		SEQ_IDLE    = 3'b001,
		SEQ_SETTLE  = 3'b010,
		SEQ_MEASURE = 3'b100
	} detect_state_t;

endpackage

// ===== design/trigger_edge_sync.sv
`timescale 1ns/1ps

module trigger_edge_sync (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic pinLevel,
	output logic      risePulse
);

	logic syncFirst;
	logic syncSecond;
	logic syncLast;

	// The first stage feeds only the second; the edge is taken between stages two and three.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			syncFirst  <= 1'b0;
			syncSecond <= 1'b0;
			syncLast   <= 1'b0;
		end else begin
			syncFirst  <= pinLevel;
			syncSecond <= syncFirst;
			syncLast   <= syncSecond;
		end
	end

	assign risePulse = syncSecond & ~syncLast;

endmodule // trigger_edge_sync

// ===== design/headset_detect_status_regs.sv
`timescale 1ns/1ps

module headset_detect_status_regs
	import headset_detect_pkg::*;
#(
	parameter int TRIGGER_DELAY_CYCLES = TRIGGER_DELAY_CYC
) (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdData,
	input  wire logic       detectTriggerPin,
	input  wire logic       micIndicatorNIn,
	output logic            micIndicatorNOut,
	output logic            micIndicatorNOen,
	output logic            measureRequest,
	input  wire logic       measureDone,
	input  wire logic       measureGroundSleeve,
	input  wire logic [2:0] measureTipSleeveBin,
	input  wire logic [2:0] measureTipRing2Bin,
	input  wire logic       measureMicFound,
	input  wire logic       measureThreePole,
	output logic            routeMicToSleeve,
	output logic            routeMicToRing2,
	output logic            routeGroundToSleeve,
	output logic            routeGroundToRing2,
	output logic            routeUpdated
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	localparam logic [DELAY_COUNT_WIDTH-1:0] DELAY_LAST =
		DELAY_COUNT_WIDTH'(TRIGGER_DELAY_CYCLES - 1);

	logic [7:0]                   detectControl;
	logic [7:0]                   detectResult;
	logic [7:0]                   detectStatusFlags;
	logic [7:0]                   statusIrqMask;
	logic                         irqPending;
	detect_state_t                seqState;
	detect_state_t                next_seqState;
	logic [DELAY_COUNT_WIDTH-1:0] delayCount;

	logic                         pinRise;
	logic                         hitControl;
	logic                         hitResult;
	logic                         hitStatus;
	logic                         hitMask;
	logic                         writeControl;
	logic                         writeResult;
	logic                         writeMask;
	logic                         readStatus;
	logic                         softwareStart;
	logic                         pinStart;
	logic                         sequenceBegin;
	logic                         measureFinish;
	logic                         delayExpired;
	logic                         forceIndicatorLow;
	logic                         pinTriggerDisable;
	logic                         indicatorIrqMode;
	logic                         autoRouteDisable;
	logic                         indicatorTristate;
	logic                         detectFailure;
	logic [7:0]                   newFlags;
	logic [7:0]                   newResult;
	logic                         newIrqEvent;
	logic [7:0]                   readMux;
	logic                         indicatorLow;
	logic                         indicatorRelease;

	////////////////////////////////////////////////////////////////////////////////
	// Trigger pin synchroniser and rising edge.

	trigger_edge_sync triggerSync (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.pinLevel  (detectTriggerPin),
		.risePulse (pinRise)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register decode.

	// Only the four mapped offsets decode; any other offset is ignored on write and reads as zero.
	assign hitControl   = (regAddr == DETECT_CONTROL_ADDR);
	assign hitResult    = (regAddr == DETECT_RESULT_ADDR);
	assign hitStatus    = (regAddr == STATUS_FLAGS_ADDR);
	assign hitMask      = (regAddr == STATUS_IRQ_MASK_ADDR);
	assign writeControl = regWrite & hitControl;
	assign writeResult  = regWrite & hitResult;
	assign writeMask    = regWrite & hitMask;
	assign readStatus   = regRead & hitStatus;

	assign forceIndicatorLow = detectControl[CTRL_FORCE_INDICATOR_LOW_BIT];
	assign pinTriggerDisable = detectControl[CTRL_PIN_TRIGGER_DISABLE_BIT];
	assign indicatorIrqMode  = detectControl[CTRL_INDICATOR_IRQ_MODE_BIT];
	assign autoRouteDisable  = detectControl[CTRL_AUTO_ROUTE_DISABLE_BIT];
	assign indicatorTristate = statusIrqMask[MASK_INDICATOR_TRISTATE_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Detection start sources.

	assign softwareStart = writeControl & regWrData[CTRL_DETECT_START_BIT];
	assign pinStart      = pinRise & ~pinTriggerDisable;
	assign sequenceBegin = (softwareStart | pinStart) & (seqState == SEQ_IDLE);
	assign delayExpired  = (delayCount == DELAY_LAST);
	assign measureFinish = (seqState == SEQ_MEASURE) & measureDone;

	////////////////////////////////////////////////////////////////////////////////
	// Detection sequencer.

	// A software start skips the settle wait; only a jack insertion needs time to seat.
	always_comb begin
		next_seqState = seqState;
		case (seqState)
			SEQ_IDLE: begin
				if (softwareStart) begin
					next_seqState = SEQ_MEASURE;
				end else if (pinStart) begin
					next_seqState = SEQ_SETTLE;
				end
			end
			SEQ_SETTLE: begin
				if (delayExpired) begin
					next_seqState = SEQ_MEASURE;
				end
			end
			SEQ_MEASURE: begin
				if (measureDone) begin
					next_seqState = SEQ_IDLE;
				end
			end
			default: begin
				next_seqState = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			seqState <= SEQ_IDLE;
		end else begin
			seqState <= next_seqState;
		end
	end

	// The counter width bounds the longest settle delay that the parameter may ask for.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			delayCount <= '0;
		end else if (seqState == SEQ_SETTLE) begin
			delayCount <= delayCount + 1'b1;
		end else begin
			delayCount <= '0;
		end
	end

	// The request stands for the whole measurement and drops after the done cycle.
	assign measureRequest = (seqState == SEQ_MEASURE);

	////////////////////////////////////////////////////////////////////////////////
	// Detection control register.

	// The start bit is an action, not a setting, so it is never stored.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			detectControl <= DETECT_CONTROL_RESET;
		end else if (writeControl) begin
			detectControl <= regWrData & CTRL_STORED_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result and status capture.

	// A measurement that finds neither plug type reports a failure.
	assign detectFailure = ~measureMicFound & ~measureThreePole;

	always_comb begin
		newResult = DETECT_RESULT_RESET;
		newResult[RESULT_GROUND_BAND_BIT] = measureGroundSleeve;
		newResult[RESULT_TIP_SLEEVE_MSB:RESULT_TIP_SLEEVE_LSB] = measureTipSleeveBin;
		newResult[RESULT_TIP_RING2_MSB:RESULT_TIP_RING2_LSB] = measureTipRing2Bin;
	end

	always_comb begin
		newFlags = STATUS_FLAGS_RESET;
		newFlags[FLAG_DETECT_FAILURE_BIT]   = detectFailure;
		newFlags[FLAG_MIC_FOUND_BIT]        = measureMicFound;
		newFlags[FLAG_THREE_POLE_FOUND_BIT] = measureThreePole;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			detectResult <= DETECT_RESULT_RESET;
		end else if (measureFinish) begin
			detectResult <= newResult;
		end else if (sequenceBegin) begin
			detectResult <= DETECT_RESULT_RESET;
		end else if (writeResult) begin
			detectResult <= regWrData & RESULT_WRITABLE_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			detectStatusFlags <= STATUS_FLAGS_RESET;
		end else if (measureFinish) begin
			detectStatusFlags <= newFlags;
		end else if (sequenceBegin) begin
			detectStatusFlags <= STATUS_FLAGS_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt mask and pending latch.

	// Mask bits 0, 1 and 3 only gate new events; a pending interrupt stays until the status is read.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			statusIrqMask <= STATUS_IRQ_MASK_RESET;
		end else if (writeMask) begin
			statusIrqMask <= regWrData & IRQ_MASK_STORED_MASK;
		end
	end

	// Only the cycle that loads a result can raise an interrupt.
	assign newIrqEvent = measureFinish & (|(newFlags & ~statusIrqMask & FLAG_EVENT_MASK));

	// A new event in the same cycle as a status read keeps the latch set.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irqPending <= 1'b0;
		end else if (newIrqEvent) begin
			irqPending <= 1'b1;
		end else if (readStatus) begin
			irqPending <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Automatic routing.

	// A three-pole plug has ring2 and sleeve shorted, so both ground switches close.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			routeMicToSleeve    <= 1'b0;
			routeMicToRing2     <= 1'b0;
			routeGroundToSleeve <= 1'b0;
			routeGroundToRing2  <= 1'b0;
			routeUpdated        <= 1'b0;
		end else if (measureFinish & ~autoRouteDisable) begin
			routeMicToSleeve    <= measureMicFound & ~measureGroundSleeve;
			routeMicToRing2     <= measureMicFound & measureGroundSleeve;
			routeGroundToSleeve <= measureGroundSleeve | measureThreePole;
			routeGroundToRing2  <= ~measureGroundSleeve | measureThreePole;
			routeUpdated        <= 1'b1;
		end else begin
			routeUpdated        <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Microphone indicator, open drain: the pin is only ever pulled low.

	always_comb begin
		indicatorLow = 1'b0;
		if (forceIndicatorLow) begin
			indicatorLow = 1'b1;
		end else if (indicatorIrqMode) begin
			indicatorLow = irqPending;
		end else begin
			indicatorLow = detectStatusFlags[FLAG_MIC_FOUND_BIT];
		end
	end

	assign micIndicatorNOut = 1'b0;
	assign indicatorRelease = ~(indicatorLow & ~indicatorTristate);

	// The enable leaves a flip-flop, so a change of mode or mask cannot glitch the pin.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			micIndicatorNOen <= 1'b1;
		end else begin
			micIndicatorNOen <= indicatorRelease;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port.

	// Read data is captured on the strobe and then held until the next read.
	always_comb begin
		readMux = UNMAPPED_READ_VALUE;
		if (hitControl) begin
			readMux = detectControl;
		end else if (hitResult) begin
			readMux = detectResult;
		end else if (hitStatus) begin
			readMux = detectStatusFlags;
		end else if (hitMask) begin
			readMux = statusIrqMask;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			regRdData <= UNMAPPED_READ_VALUE;
		end else if (regRead) begin
			regRdData <= readMux;
		end
	end

endmodule // headset_detect_status_regs

// ===== testbench/analog_measure_model.sv
`timescale 1ns/1ps

// Answers each measurement request after a chosen number of cycles.
// Outside the answer cycle the results show the inverse of the outcome.
module analog_measure_model (
	input  wire logic       core_clk,
	input  wire logic       measureRequest,
	input  wire logic [8:0] outcome,
	input  wire logic [3:0] lag,
	output logic            measureDone,
	output logic [8:0]      answer
);
	logic [3:0] waited = 4'h0;

	initial measureDone = 1'b0;
	initial answer = 9'h000;

	always @(posedge core_clk) begin
		measureDone <= 1'b0;
		answer <= ~outcome;
		waited <= 4'h0;
		if (measureRequest && !measureDone) begin
			waited <= waited + 4'h1;
			if (waited == lag) begin
				measureDone <= 1'b1;
				answer <= outcome;
			end
		end
	end
endmodule // analog_measure_model

// ===== testbench/headset_detect_status_regs_checker.sv
`timescale 1ns/1ps

module headset_detect_status_regs_checker (
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic [7:0] regAddr,
	input wire logic       regRead,
	input wire logic [7:0] regRdData,
	input wire logic       micIndicatorNOut,
	input wire logic       micIndicatorNOen,
	input wire logic       measureRequest,
	input wire logic       measureDone,
	input wire logic       measureGroundSleeve,
	input wire logic       measureMicFound,
	input wire logic       routeMicToSleeve,
	input wire logic       routeMicToRing2,
	input wire logic       routeGroundToSleeve,
	input wire logic       routeGroundToRing2,
	input wire logic       routeUpdated
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_done;
		measureRequest && measureDone;
	endsequence
	sequence s_mic_sleeve_gnd;
		(s_done ##0 (measureMicFound && measureGroundSleeve)) ##1 routeUpdated;
	endsequence
	sequence s_mic_ring2_gnd;
		(s_done ##0 (measureMicFound && !measureGroundSleeve)) ##1 routeUpdated;
	endsequence

	property p_reset_state;
		$rose(resetn) |-> micIndicatorNOen && !measureRequest && !routeUpdated && regRdData == 8'h00;
	endproperty
	property p_request_holds;
		measureRequest && !measureDone |=> measureRequest;
	endproperty
	property p_request_ends;
		s_done |=> !measureRequest;
	endproperty
	property p_route_ring2;
		s_mic_sleeve_gnd |-> routeMicToRing2 && routeGroundToSleeve && !routeMicToSleeve;
	endproperty
	property p_route_sleeve;
		s_mic_ring2_gnd |-> routeMicToSleeve && routeGroundToRing2 && !routeMicToRing2;
	endproperty
	property p_route_cause;
		routeUpdated |-> $past(measureRequest && measureDone);
	endproperty
	property p_route_hold;
		!routeUpdated |-> $stable({routeMicToSleeve, routeMicToRing2, routeGroundToSleeve, routeGroundToRing2});
	endproperty
	property p_flag_reserved;
		regRead && regAddr == 8'h06 |=> regRdData[7:4] == 4'h0 && !regRdData[2];
	endproperty
	property p_result_reserved;
		regRead && regAddr == 8'h05 |=> !regRdData[7];
	endproperty
	property p_open_drain;
		micIndicatorNOut == 1'b0;
	endproperty

	a_reset_state: assert property (p_reset_state) else $error("state after reset wrong");
	a_request_holds: assert property (p_request_holds) else $error("request dropped early");
	a_request_ends: assert property (p_request_ends) else $error("request kept after done");
	a_route_ring2: assert property (p_route_ring2) else $error("microphone not on ring2");
	a_route_sleeve: assert property (p_route_sleeve) else $error("microphone not on sleeve");
	a_route_cause: assert property (p_route_cause) else $error("routing without detection");
	a_route_hold: assert property (p_route_hold) else $error("routing changed silently");
	a_flag_reserved: assert property (p_flag_reserved) else $error("reserved flag bits set");
	a_result_reserved: assert property (p_result_reserved) else $error("reserved result bit set");
	a_open_drain: assert property (p_open_drain) else $error("indicator drives high");
endmodule // headset_detect_status_regs_checker

bind headset_detect_status_regs headset_detect_status_regs_checker headset_detect_status_regs_checker_inst (.*);

// ===== testbench/headset_detect_status_regs_test.sv
`timescale 1ns/1ps

module headset_detect_status_regs_test
	import headset_detect_pkg::*;
;
	localparam int DLY = 20;
	logic       core_clk = 1'b0;
	logic       resetn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic       regWrite = 1'b0;
	logic       regRead = 1'b0;
	logic       detectTriggerPin = 1'b0;
	logic [8:0] outcome = 9'h000;
	logic [3:0] lag = 4'h0;
	logic [8:0] answer;
	logic [7:0] regRdData;
	logic       micIndicatorNOut, micIndicatorNOen, measureRequest, measureDone, routeUpdated;
	logic       routeMicToSleeve, routeMicToRing2, routeGroundToSleeve, routeGroundToRing2;
	int         err_count = 0;
	int         tests_run = 0;
	int         updates = 0;
	logic [7:0] regs [5] = '{8'h41, 8'h05, 8'h06, 8'h07, 8'h00};
	logic [7:0] masks [3] = '{8'h08, 8'h02, 8'h01};
	logic [8:0] outs [3] = '{9'h000, 9'h102, 9'h001};

	headset_detect_status_regs #(.TRIGGER_DELAY_CYCLES(DLY)) headset_detect_status_regs_inst (
		.core_clk, .resetn, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .detectTriggerPin,
		.micIndicatorNIn(1'b1), .micIndicatorNOut, .micIndicatorNOen, .measureRequest, .measureDone,
		.measureGroundSleeve(answer[8]), .measureTipSleeveBin(answer[7:5]), .measureTipRing2Bin(answer[4:2]),
		.measureMicFound(answer[1]), .measureThreePole(answer[0]), .routeMicToSleeve, .routeMicToRing2,
		.routeGroundToSleeve, .routeGroundToRing2, .routeUpdated
	);
	analog_measure_model analog_measure_model_inst (.core_clk, .measureRequest, .outcome, .lag, .measureDone, .answer);

	initial begin
		forever #4 core_clk = ~core_clk;
	end

	always @(posedge core_clk) if (routeUpdated === 1'b1) updates <= updates + 1;

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		@(negedge core_clk);
		check($sformatf("reg %h", a), regRdData, exp);
		@(posedge core_clk);
	endtask

	task automatic run(input logic [7:0] ctrl, input logic [8:0] o);
		int n;
		outcome <= o;
		wr(8'h41, ctrl | 8'h01);
		if (lag > 4'h4) rd(8'h06, 8'h00);
		for (n = 0; n < 50 && measureDone !== 1'b1; n++) @(posedge core_clk);
		check("done", n < 50, 1);
		repeat (2) @(posedge core_clk);
	endtask

	task automatic complete_run();
		if (err_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// A full run takes well under a thousand cycles; twenty thousand means a hang.
	initial begin
		#(20000 * 8);
		err_count++;
		complete_run();
	end

	initial begin
		int n;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		foreach (regs[i]) rd(regs[i], 8'h00);
		check("oen", micIndicatorNOen, 1);
		wr(8'h05, 8'hFF);
		rd(8'h05, 8'h7F);
		wr(8'h06, 8'hFF);
		rd(8'h06, 8'h00);
		for (int i = 0; i < 8; i++) begin
			lag <= 4'(i);
			run(8'h00, {i[0], 3'(i), 3'(7 - i), 2'b10});
			check("oen", micIndicatorNOen, 0);
			check("micToRing2", routeMicToRing2, i[0]);
			check("gndToRing2", routeGroundToRing2, !i[0]);
			rd(8'h05, {1'b0, i[0], 3'(i), 3'(7 - i)});
			rd(8'h06, 8'h02);
		end
		run(8'h00, 9'h000);
		check("oen", micIndicatorNOen, 1);
		rd(8'h06, 8'h08);
		n = updates;
		run(8'h06, 9'h001);
		check("updates", 8'(updates - n), 0);
		check("oen", micIndicatorNOen, 0);
		rd(8'h06, 8'h01);
		@(posedge core_clk);
		check("oen", micIndicatorNOen, 1);
		foreach (masks[j]) begin
			wr(8'h07, masks[j]);
			run(8'h04, outs[j]);
			check("oen", micIndicatorNOen, 1);
		end
		rd(8'h07, 8'h01);
		wr(8'h41, 8'h10);
		@(posedge core_clk);
		check("oen", micIndicatorNOen, 0);
		rd(8'h41, 8'h10);
		wr(8'h07, 8'h10);
		@(posedge core_clk);
		check("oen", micIndicatorNOen, 1);
		wr(8'h07, 8'h00);
		wr(8'h41, 8'h08);
		detectTriggerPin <= 1'b1;
		repeat (DLY + 10) @(posedge core_clk);
		check("request", measureRequest, 0);
		detectTriggerPin <= 1'b0;
		wr(8'h41, 8'h00);
		repeat (4) @(posedge core_clk);
		detectTriggerPin <= 1'b1;
		for (n = 0; n < 60 && measureRequest !== 1'b1; n++) @(posedge core_clk);
		check("delay", n > DLY && n < DLY + 8, 1);
		repeat (20) @(posedge core_clk);
		rd(8'h06, 8'h01);
		complete_run();
	end
endmodule // headset_detect_status_regs_test
